// ---- audio_function_group_verbs.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Root parameter 00h returns vendor id high half, device id low half.
// - Root parameter 02h: major revision 1, minor 0, revision and stepping zero.
// - Root parameter 04h: first child 01h, one child.
// - Group parameter 04h: first widget 10h, widget count 18h.
// - Group parameter 05h: type 01h, bit 8 zero.
// - Group parameter 08h: no beep, input delay 3h, output delay 6h.
// - Group parameter 0Fh: D0 to D3 supported, upper bits zero.
// - Parameter 11h: events supported, no wake, one or two bidirectional pins.
// - Board identifier written bytewise by 720h-723h, read whole by F20h.
// - Board identifier: maker code high, variant and assembly bytes default 00h.
// - Power state set by 705h with 0..3, read by F05h.
// - Power response holds requested state low, equal actual state above.
// - Group power state controls power-down of the whole chip.
// - Event control via 708h/F08h, enable bit 7 resets to zero.
// - Event control bits 5:0 hold the tag, bit 6 reads zero.
// - 715h sets output pin levels only for outputs; F15h reads both levels.
// - Enable mask 716h/F16h defaults off, pin then undriven.
// - Direction 717h/F17h: zero input default, one output.
// - Change-event mask 719h/F19h defaults zero; set bits report pin changes.
// - Verb 7FFh with zero payload to the group is a function reset.
// - D1 powers down amplifiers and converters; D2 and D3 also the reference.
module audio_function_group_verbs
    import verb_responder_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h0A0A, // Arbitrary value
    parameter int PIN_COUNT = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_verb_valid,
    input wire logic [7:0] i_verb_node,
    input wire logic [11:0] i_verb_code,
    input wire logic [7:0] i_verb_payload,
    output logic o_verb_ready,
    output logic o_resp_valid,
    output logic [31:0] o_resp_data,
    output logic o_unsol_valid,
    output logic [31:0] o_unsol_data,
    input wire logic [PIN_COUNT-1:0] i_general_pin,
    output logic [PIN_COUNT-1:0] o_general_pin,
    output logic [PIN_COUNT-1:0] o_general_pin_oe,
    output logic o_chip_powered_down,
    output logic o_amps_converters_off,
    output logic o_analog_reference_off,
    output logic o_second_digital_audio_out_sel
);

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic pend;
        logic [7:0] node;
        logic [11:0] code;
        logic [7:0] payload;
        logic verb_tgl;
        logic [2:0] resp_sync;
        logic resp_seen;
        logic [2:0] unsol_sync;
        logic unsol_seen;
        logic ack_tgl;
        logic ready;
        logic resp_valid;
        logic [31:0] resp_data;
        logic unsol_valid;
        logic [31:0] unsol_data;
    } link_state_type;

    typedef struct packed {
        logic [2:0] verb_sync;
        logic verb_seen;
        logic resp_tgl;
        logic [31:0] resp_data;
        logic [2:0] ack_sync;
        logic ack_seen;
        logic unsol_tgl;
        logic unsol_busy;
        logic [31:0] unsol_data;
        logic [PIN_COUNT-1:0] pend_chg;
        logic [PIN_COUNT-1:0] pin_s1;
        logic [PIN_COUNT-1:0] pin_s2;
        logic [PIN_COUNT-1:0] pin_s3;
        logic [PIN_COUNT-1:0] pin_lvl;
        logic [31:0] board_id;
        logic [3:0] power;
        logic [7:0] event_ctrl;
        logic [PIN_COUNT-1:0] levels;
        logic [PIN_COUNT-1:0] enable;
        logic [PIN_COUNT-1:0] dir;
        logic [PIN_COUNT-1:0] event_mask;
        logic [7:0] vendor_setting;
        logic [PIN_COUNT-1:0] pin_out;
        logic [PIN_COUNT-1:0] pin_oe;
        logic chip_down;
        logic amps_off;
        logic ref_off;
    } core_state_type;

    link_state_type link_ff, nxt_link;
    core_state_type core_ff, nxt_core;

    // A toggle counts as arrived once the 2nd and 3rd stages agree and differ from the last seen level
    function automatic logic toggle_arrived(input logic [2:0] sync, input logic seen);
        toggle_arrived = (sync[1] == sync[2]) && (sync[2] != seen);
    endfunction

    function automatic logic [31:0] zext(input logic [PIN_COUNT-1:0] v);
        zext = 32'h0000_0000;
        zext[PIN_COUNT-1:0] = v;
    endfunction

    // ------------------------------------------------------------
    // Link side: verb capture, response and event delivery
    // ------------------------------------------------------------
    always_comb begin
        nxt_link = link_ff;
        nxt_link.resp_sync = {link_ff.resp_sync[1:0], core_ff.resp_tgl};
        nxt_link.unsol_sync = {link_ff.unsol_sync[1:0], core_ff.unsol_tgl};
        nxt_link.resp_valid = 1'b0;
        nxt_link.unsol_valid = 1'b0;
        // One verb in flight: the word stays frozen until the core answers
        if (i_verb_valid && !link_ff.pend) begin
            nxt_link.pend = 1'b1;
            nxt_link.node = i_verb_node;
            nxt_link.code = i_verb_code;
            nxt_link.payload = i_verb_payload;
            nxt_link.verb_tgl = ~link_ff.verb_tgl;
        end
        if (toggle_arrived(link_ff.resp_sync, link_ff.resp_seen)) begin
            nxt_link.resp_seen = link_ff.resp_sync[2];
            nxt_link.resp_valid = 1'b1;
            nxt_link.resp_data = core_ff.resp_data;
            nxt_link.pend = 1'b0;
        end
        if (toggle_arrived(link_ff.unsol_sync, link_ff.unsol_seen)) begin
            nxt_link.unsol_seen = link_ff.unsol_sync[2];
            nxt_link.unsol_valid = 1'b1;
            nxt_link.unsol_data = core_ff.unsol_data;
            nxt_link.ack_tgl = ~link_ff.ack_tgl;
        end
        nxt_link.ready = !nxt_link.pend;
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            link_ff <= '0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    // ------------------------------------------------------------
    // Core side: verb decode, registers, pins
    // ------------------------------------------------------------
    always_comb begin
        logic take;
        logic to_group;
        logic [7:0] pl;
        logic [31:0] resp;
        logic [PIN_COUNT-1:0] live;
        logic [PIN_COUNT-1:0] chg;
        logic [7:0] pin_total;
        take = toggle_arrived(core_ff.verb_sync, core_ff.verb_seen);
        to_group = link_ff.node == NODE_AUDIO_GROUP;
        pl = link_ff.payload;
        resp = 32'h0000_0000;
        nxt_core = core_ff;
        nxt_core.verb_sync = {core_ff.verb_sync[1:0], link_ff.verb_tgl};
        nxt_core.ack_sync = {core_ff.ack_sync[1:0], link_ff.ack_tgl};
        nxt_core.pin_s1 = i_general_pin;
        nxt_core.pin_s2 = core_ff.pin_s1;
        nxt_core.pin_s3 = core_ff.pin_s2;
        // A pin level is accepted only where stages 2 and 3 agree
        live = (core_ff.pin_lvl & (core_ff.pin_s2 ^ core_ff.pin_s3))
            | (core_ff.pin_s3 & (core_ff.pin_s2 ~^ core_ff.pin_s3));
        chg = live ^ core_ff.pin_lvl;
        nxt_core.pin_lvl = live;
        pin_total = core_ff.vendor_setting[SECOND_OUT_SEL_BIT] ? PINS_WITH_DIGITAL_OUT : PINS_ALL_GENERAL;

        if (take) begin
            nxt_core.verb_seen = core_ff.verb_sync[2];
            if (link_ff.code == VERB_GET_PARAM) begin
                if (link_ff.node == NODE_ROOT) begin
                    if (pl == PARAM_IDENTITY) begin
                        resp = {VENDOR_CODE, DEVICE_CODE};
                    end else if (pl == PARAM_REVISION) begin
                        resp = {8'h00, MAJOR_COMPLIANCE_REVISION, MINOR_COMPLIANCE_REVISION, 16'h0000};
                    end else if (pl == PARAM_NODE_COUNT) begin
                        resp = {8'h00, ROOT_FIRST_CHILD, 8'h00, ROOT_CHILD_COUNT};
                    end
                end else if (to_group) begin
                    if (pl == PARAM_NODE_COUNT) begin
                        resp = {8'h00, GROUP_FIRST_WIDGET, 8'h00, GROUP_WIDGET_COUNT};
                    end else if (pl == PARAM_GROUP_TYPE) begin
                        resp = {24'h00_0000, GROUP_TYPE_AUDIO};
                    end else if (pl == PARAM_GROUP_CAPS) begin
                        resp = {20'h0_0000, GROUP_INPUT_DELAY, 4'h0, GROUP_OUTPUT_DELAY};
                    end else if (pl == PARAM_POWER_STATES) begin
                        resp = {28'h000_0000, POWER_STATES_ALL};
                    end else if (pl == PARAM_PIN_CAPS) begin
                        // No wake, events supported, no input-only or output-only pins
                        resp = {2'b01, 22'h00_0000, pin_total};
                    end
                end
            end else if (to_group) begin
                if (link_ff.code == VERB_GET_BOARD_ID) begin
                    resp = core_ff.board_id;
                end else if (link_ff.code == VERB_SET_BOARD_ID0) begin
                    nxt_core.board_id[7:0] = pl;
                end else if (link_ff.code == VERB_SET_BOARD_ID1) begin
                    nxt_core.board_id[15:8] = pl;
                end else if (link_ff.code == VERB_SET_BOARD_ID2) begin
                    nxt_core.board_id[23:16] = pl;
                end else if (link_ff.code == VERB_SET_BOARD_ID3) begin
                    nxt_core.board_id[31:24] = pl;
                end else if (link_ff.code == VERB_GET_POWER) begin
                    resp = {24'h00_0000, core_ff.power, core_ff.power};
                end else if (link_ff.code == VERB_SET_POWER) begin
                    // Out-of-range states are ignored so the chip never sits in an undefined state
                    if (pl[7:4] == 4'h0 && pl[3:0] <= POWER_D3) begin
                        nxt_core.power = pl[3:0];
                    end
                end else if (link_ff.code == VERB_GET_EVENT_CTRL) begin
                    resp = {24'h00_0000, core_ff.event_ctrl};
                end else if (link_ff.code == VERB_SET_EVENT_CTRL) begin
                    nxt_core.event_ctrl = pl & EVENT_CTRL_WRITE_MASK;
                end else if (link_ff.code == VERB_GET_PIN_LEVELS) begin
                    resp = zext((core_ff.dir & core_ff.levels) | (~core_ff.dir & core_ff.pin_lvl));
                end else if (link_ff.code == VERB_SET_PIN_LEVELS) begin
                    nxt_core.levels = (core_ff.dir & pl[PIN_COUNT-1:0]) | (~core_ff.dir & core_ff.levels);
                end else if (link_ff.code == VERB_GET_PIN_ENABLE) begin
                    resp = zext(core_ff.enable);
                end else if (link_ff.code == VERB_SET_PIN_ENABLE) begin
                    nxt_core.enable = pl[PIN_COUNT-1:0];
                end else if (link_ff.code == VERB_GET_PIN_DIR) begin
                    resp = zext(core_ff.dir);
                end else if (link_ff.code == VERB_SET_PIN_DIR) begin
                    nxt_core.dir = pl[PIN_COUNT-1:0];
                end else if (link_ff.code == VERB_GET_PIN_EVENT) begin
                    resp = zext(core_ff.event_mask);
                end else if (link_ff.code == VERB_SET_PIN_EVENT) begin
                    nxt_core.event_mask = pl[PIN_COUNT-1:0];
                end else if (link_ff.code == VERB_GET_VENDOR_SETTING) begin
                    resp = {24'h00_0000, core_ff.vendor_setting};
                end else if (link_ff.code == VERB_SET_VENDOR_SETTING) begin
                    nxt_core.vendor_setting = pl;
                end else if (link_ff.code == VERB_FUNCTION_RESET && pl == 8'h00) begin
                    // Link handshake state and board identifier survive the reset
                    nxt_core.power = POWER_D0;
                    nxt_core.event_ctrl = 8'h00;
                    nxt_core.levels = '0;
                    nxt_core.enable = '0;
                    nxt_core.dir = '0;
                    nxt_core.event_mask = '0;
                    nxt_core.pend_chg = '0;
                end
            end
            nxt_core.resp_data = resp;
            nxt_core.resp_tgl = ~core_ff.resp_tgl;
        end

        // Pin change reporting
        if (toggle_arrived(core_ff.ack_sync, core_ff.ack_seen)) begin
            nxt_core.ack_seen = core_ff.ack_sync[2];
            nxt_core.unsol_busy = 1'b0;
        end
        if (core_ff.event_ctrl[EVENT_ENABLE_BIT]) begin
            // A change during a busy report waits and is sent next, never dropped
            nxt_core.pend_chg = nxt_core.pend_chg | (chg & core_ff.event_mask);
        end
        if (!core_ff.unsol_busy && core_ff.pend_chg != '0 && core_ff.event_ctrl[EVENT_ENABLE_BIT]) begin
            nxt_core.unsol_data = {core_ff.event_ctrl[5:0], 26'h000_0000} | zext(core_ff.pend_chg);
            nxt_core.unsol_tgl = ~core_ff.unsol_tgl;
            nxt_core.unsol_busy = 1'b1;
            nxt_core.pend_chg = chg & core_ff.event_mask;
        end

        // Pin drive: disabled pins float, enabled follow direction; the last pin floats while the second output is selected
        nxt_core.pin_oe = nxt_core.enable & nxt_core.dir;
        if (nxt_core.vendor_setting[SECOND_OUT_SEL_BIT]) begin
            nxt_core.pin_oe[PIN_COUNT-1] = 1'b0;
        end
        nxt_core.pin_out = nxt_core.levels;
        nxt_core.chip_down = nxt_core.power != POWER_D0;
        nxt_core.amps_off = nxt_core.power >= POWER_D1;
        nxt_core.ref_off = nxt_core.power >= POWER_D2;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            core_ff <= '0;
            core_ff.board_id <= {VENDOR_CODE, BOARD_LOW_BYTES_RESET, BOARD_LOW_BYTES_RESET};
        end else begin
            core_ff <= nxt_core;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_verb_ready = link_ff.ready;
    assign o_resp_valid = link_ff.resp_valid;
    assign o_resp_data = link_ff.resp_data;
    assign o_unsol_valid = link_ff.unsol_valid;
    assign o_unsol_data = link_ff.unsol_data;
    assign o_general_pin = core_ff.pin_out;
    assign o_general_pin_oe = core_ff.pin_oe;
    assign o_chip_powered_down = core_ff.chip_down;
    assign o_amps_converters_off = core_ff.amps_off;
    assign o_analog_reference_off = core_ff.ref_off;
    assign o_second_digital_audio_out_sel = core_ff.vendor_setting[SECOND_OUT_SEL_BIT];

endmodule

// ---- host_verb_model.sv ----
`timescale 1ns/10ps
module host_verb_model (
    input wire logic i_link_clk,
    output logic o_verb_valid,
    output logic [7:0] o_verb_node,
    output logic [11:0] o_verb_code,
    output logic [7:0] o_verb_payload,
    input wire logic i_verb_ready,
    input wire logic i_resp_valid,
    input wire logic [31:0] i_resp_data,
    input wire logic i_unsol_valid,
    input wire logic [31:0] i_unsol_data
);
    int n_unsol = 0;
    logic [31:0] unsol_seen = 32'h0;
    initial begin
        o_verb_valid = 1'b0;
        o_verb_node = 8'hA5;
        o_verb_code = 12'h5A5;
        o_verb_payload = 8'h5A;
    end
    always @(negedge i_link_clk) begin
        if (i_unsol_valid) begin
            n_unsol++;
            unsol_seen = i_unsol_data;
        end
    end
    // Gap models a slow host; released fields show their inverse so stale values never pass
    task automatic issue(input logic [7:0] nd, input logic [11:0] c, input logic [7:0] p, input int gap,
                         output logic [31:0] data, output bit ok);
        int n;
        repeat (gap + 1) @(negedge i_link_clk);
        o_verb_valid = 1'b1;
        o_verb_node = nd;
        o_verb_code = c;
        o_verb_payload = p;
        for (n = 0; n < 40 && !i_verb_ready; n++) @(negedge i_link_clk);
        ok = i_verb_ready;
        @(posedge i_link_clk);
        @(negedge i_link_clk);
        o_verb_valid = 1'b0;
        o_verb_node = ~nd;
        o_verb_code = ~c;
        o_verb_payload = ~p;
        for (n = 0; n < 60 && !i_resp_valid; n++) @(negedge i_link_clk);
        ok = ok && i_resp_valid;
        data = i_resp_data;
    endtask
endmodule

// ---- test_audio_function_group_verbs.sv ----
`timescale 1ns/10ps
module test_audio_function_group_verbs;
    import verb_responder_pkg::*;
    localparam logic [15:0] VEND = 16'h3C3C; // Arbitrary value
    localparam logic [15:0] DEV = 16'h0C0C; // Arbitrary value
    localparam logic [15:0] PN [9] = '{16'h0000, 16'h0002, 16'h0004, 16'h0104, 16'h0105, 16'h0108, 16'h010F,
                                       16'h0111, 16'h0500};
    localparam logic [11:0] RV [5] = '{VERB_GET_POWER, VERB_GET_EVENT_CTRL, VERB_GET_PIN_ENABLE,
                                       VERB_GET_PIN_DIR, VERB_GET_PIN_EVENT};
    logic i_core_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] ext_pin = 2'b00;
    logic vv, rdy, rv, uv, pd, amp_off, ref_off, sel;
    logic [7:0] node, pl;
    logic [11:0] code;
    logic [31:0] rd, ud, got, bid;
    logic [1:0] pin_o, pin_oe, pin_w;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    bit ok;
    assign pin_w = (pin_o & pin_oe) | (ext_pin & ~pin_oe);
    initial forever #12.5 i_core_clk = ~i_core_clk;
    initial begin
        #3.7;
        forever #7.5 i_link_clk = ~i_link_clk;
    end
    audio_function_group_verbs #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEV), .PIN_COUNT(2)) DUT (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_verb_valid(vv), .i_verb_node(node),
        .i_verb_code(code), .i_verb_payload(pl), .o_verb_ready(rdy), .o_resp_valid(rv), .o_resp_data(rd),
        .o_unsol_valid(uv), .o_unsol_data(ud), .i_general_pin(pin_w), .o_general_pin(pin_o),
        .o_general_pin_oe(pin_oe), .o_chip_powered_down(pd), .o_amps_converters_off(amp_off),
        .o_analog_reference_off(ref_off), .o_second_digital_audio_out_sel(sel));
    host_verb_model m (.i_link_clk(i_link_clk), .o_verb_valid(vv), .o_verb_node(node), .o_verb_code(code),
        .o_verb_payload(pl), .i_verb_ready(rdy), .i_resp_valid(rv), .i_resp_data(rd), .i_unsol_valid(uv),
        .i_unsol_data(ud));
    function automatic logic [31:0] exp_param(input logic [15:0] np, input logic s);
        case (np)
            16'h0000: return {VEND, DEV};
            16'h0002: return 32'h0010_0000;
            16'h0004: return 32'h0001_0001;
            16'h0104: return 32'h0010_0018;
            16'h0105: return 32'h0000_0001;
            16'h0108: return 32'h0000_0306;
            16'h010F: return 32'h0000_000F;
            16'h0111: return s ? 32'h4000_0001 : 32'h4000_0002;
            default: return 32'h0;
        endcase
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic verb(input logic [7:0] nd, input logic [11:0] c, input logic [7:0] p);
        m.issue(nd, c, p, $urandom_range(0, 2), got, ok);
        check("handshake", 32'h1, {31'h0, ok});
    endtask
    task automatic rd_chk(input string what, input logic [11:0] c, input logic [31:0] exp);
        verb(NODE_AUDIO_GROUP, c, 8'h00);
        check(what, exp, got);
    endtask
    // No report is judged after the full wait
    task automatic pin_step(input logic [1:0] v, input int want);
        int n, s;
        s = m.n_unsol;
        @(negedge i_core_clk);
        ext_pin = v;
        for (n = 0; n < 150 && m.n_unsol == s; n++) @(negedge i_core_clk);
        check("report count", want, m.n_unsol);
    endtask
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        int i;
        logic [7:0] b [4];
        logic [5:0] tag;
        i = $urandom(32'hC508);
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst = 1'b0;
        for (i = 0; i < 9; i++) begin
            verb(PN[i][15:8], VERB_GET_PARAM, PN[i][7:0]);
            check("parameter", exp_param(PN[i], 1'b0), got);
        end
        verb(NODE_AUDIO_GROUP, VERB_SET_VENDOR_SETTING, 8'h10);
        verb(NODE_AUDIO_GROUP, VERB_GET_PARAM, PARAM_PIN_CAPS);
        check("pin caps", exp_param(16'h0111, 1'b1), got);
        check("second out", 32'h1, {31'h0, sel});
        verb(NODE_AUDIO_GROUP, VERB_SET_VENDOR_SETTING, 8'h00);
        $display("test parameters done");
        rd_chk("board id", VERB_GET_BOARD_ID, {VEND, 16'h0000});
        for (i = 0; i < 4; i++) begin
            b[i] = 8'($urandom);
            verb(NODE_AUDIO_GROUP, VERB_SET_BOARD_ID0 + 12'(i), b[i]);
        end
        bid = {b[3], b[2], b[1], b[0]};
        rd_chk("board id", VERB_GET_BOARD_ID, bid);
        $display("test board id done");
        for (i = 3; i >= 0; i--) begin
            verb(NODE_AUDIO_GROUP, VERB_SET_POWER, 8'(i));
            rd_chk("power", VERB_GET_POWER, {24'h0, 4'(i), 4'(i)});
            repeat (2) @(negedge i_core_clk);
            check("power outs", {29'h0, i >= 2, i >= 1, i != 0}, {29'h0, ref_off, amp_off, pd});
        end
        verb(NODE_AUDIO_GROUP, VERB_SET_POWER, 8'h04);
        rd_chk("power", VERB_GET_POWER, 32'h0);
        $display("test power done");
        rd_chk("event ctrl", VERB_GET_EVENT_CTRL, 32'h0);
        b[0] = 8'($urandom);
        verb(NODE_AUDIO_GROUP, VERB_SET_EVENT_CTRL, b[0]);
        rd_chk("event ctrl", VERB_GET_EVENT_CTRL, {24'h0, b[0] & 8'hBF});
        for (i = 2; i < 5; i++) rd_chk("pin reg", RV[i], 32'h0);
        verb(NODE_AUDIO_GROUP, VERB_SET_PIN_DIR, 8'h01);
        verb(NODE_AUDIO_GROUP, VERB_SET_PIN_LEVELS, 8'h03);
        pin_step(2'b10, 0);
        check("oe off", 32'h0, {30'h0, pin_oe});
        verb(NODE_AUDIO_GROUP, VERB_SET_PIN_ENABLE, 8'h03);
        repeat (2) @(negedge i_core_clk);
        check("oe dir", 32'h5, {28'h0, pin_o, pin_oe});
        rd_chk("levels", VERB_GET_PIN_LEVELS, 32'h3);
        verb(NODE_AUDIO_GROUP, VERB_SET_PIN_LEVELS, 8'h00);
        rd_chk("levels", VERB_GET_PIN_LEVELS, 32'h2);
        $display("test pins done");
        tag = 6'($urandom);
        verb(NODE_AUDIO_GROUP, VERB_SET_EVENT_CTRL, {2'b10, tag});
        verb(NODE_AUDIO_GROUP, VERB_SET_PIN_EVENT, 8'h02);
        pin_step(2'b00, 1);
        check("report", {tag, 24'h0, 2'b10}, m.unsol_seen);
        verb(NODE_AUDIO_GROUP, VERB_SET_EVENT_CTRL, {2'b00, tag});
        pin_step(2'b10, 1);
        $display("test reports done");
        verb(NODE_AUDIO_GROUP, VERB_SET_POWER, 8'h03);
        verb(NODE_AUDIO_GROUP, VERB_FUNCTION_RESET, 8'h00);
        for (i = 0; i < 5; i++) rd_chk("after reset", RV[i], 32'h0);
        rd_chk("board id kept", VERB_GET_BOARD_ID, bid);
        check("oe after reset", 32'h0, {30'h0, pin_oe});
        $display("test function reset done");
        end_sim();
    end
endmodule

// ---- verb_responder_monitor.sv ----
`timescale 1ns/10ps
module verb_responder_monitor (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_verb_valid,
    input wire logic o_verb_ready,
    input wire logic o_resp_valid,
    input wire logic [31:0] o_resp_data,
    input wire logic o_unsol_valid,
    input wire logic [31:0] o_unsol_data,
    input wire logic o_chip_powered_down,
    input wire logic o_amps_converters_off,
    input wire logic o_analog_reference_off
);
    chk_take_answer: assert property (@(posedge i_link_clk) disable iff (i_rst)
        i_verb_valid && o_verb_ready |=> !o_verb_ready ##[0:40] o_resp_valid) else $error("verb left unanswered");
    chk_resp_pulse: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_resp_valid |=> !o_resp_valid && o_verb_ready) else $error("response pulse too long");
    chk_resp_hold: assert property (@(posedge i_link_clk) disable iff (i_rst)
        !o_resp_valid |-> $stable(o_resp_data)) else $error("response data moved while idle");
    chk_unsol_pulse: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_unsol_valid |=> !o_unsol_valid) else $error("report pulse too long");
    chk_unsol_shape: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_unsol_valid |-> o_unsol_data[25:2] == 24'h0 && o_unsol_data[1:0] != 2'b00) else $error("bad report");
    chk_unsol_hold: assert property (@(posedge i_link_clk) disable iff (i_rst)
        !o_unsol_valid |-> $stable(o_unsol_data)) else $error("report data moved while idle");
    chk_ref_amps: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_analog_reference_off |-> o_amps_converters_off) else $error("reference off with amps on");
    chk_amps_chip: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_amps_converters_off == o_chip_powered_down) else $error("amps disagree with chip power");
    cover property (@(posedge i_link_clk) disable iff (i_rst) o_unsol_valid);
    cover property (@(posedge i_link_clk) disable iff (i_rst) o_resp_valid ##1 i_verb_valid);
    cover property (@(posedge i_core_clk) disable iff (i_rst) $fell(o_analog_reference_off));
endmodule
bind audio_function_group_verbs verb_responder_monitor u_mon (.i_core_clk, .i_rst, .i_link_clk, .i_verb_valid,
    .o_verb_ready, .o_resp_valid, .o_resp_data, .o_unsol_valid, .o_unsol_data, .o_chip_powered_down,
    .o_amps_converters_off, .o_analog_reference_off);

// ---- verb_responder_pkg.sv ----
package verb_responder_pkg;
    // Node addresses
    localparam logic [7:0] NODE_ROOT = 8'h00;
    localparam logic [7:0] NODE_AUDIO_GROUP = 8'h01;
    // Verb codes (12-bit form, 8-bit payload)
    localparam logic [11:0] VERB_GET_PARAM = 12'hF00;
    localparam logic [11:0] VERB_GET_POWER = 12'hF05;
    localparam logic [11:0] VERB_SET_POWER = 12'h705;
    localparam logic [11:0] VERB_GET_EVENT_CTRL = 12'hF08;
    localparam logic [11:0] VERB_SET_EVENT_CTRL = 12'h708;
    localparam logic [11:0] VERB_GET_PIN_LEVELS = 12'hF15;
    localparam logic [11:0] VERB_SET_PIN_LEVELS = 12'h715;
    localparam logic [11:0] VERB_GET_PIN_ENABLE = 12'hF16;
    localparam logic [11:0] VERB_SET_PIN_ENABLE = 12'h716;
    localparam logic [11:0] VERB_GET_PIN_DIR = 12'hF17;
    localparam logic [11:0] VERB_SET_PIN_DIR = 12'h717;
    localparam logic [11:0] VERB_GET_PIN_EVENT = 12'hF19;
    localparam logic [11:0] VERB_SET_PIN_EVENT = 12'h719;
    localparam logic [11:0] VERB_GET_BOARD_ID = 12'hF20;
    localparam logic [11:0] VERB_SET_BOARD_ID0 = 12'h720;
    localparam logic [11:0] VERB_SET_BOARD_ID1 = 12'h721;
    localparam logic [11:0] VERB_SET_BOARD_ID2 = 12'h722;
    localparam logic [11:0] VERB_SET_BOARD_ID3 = 12'h723;
    localparam logic [11:0] VERB_GET_VENDOR_SETTING = 12'hF83;
    localparam logic [11:0] VERB_SET_VENDOR_SETTING = 12'h783;
    localparam logic [11:0] VERB_FUNCTION_RESET = 12'h7FF;
    // Parameter ids
    localparam logic [7:0] PARAM_IDENTITY = 8'h00;
    localparam logic [7:0] PARAM_REVISION = 8'h02;
    localparam logic [7:0] PARAM_NODE_COUNT = 8'h04;
    localparam logic [7:0] PARAM_GROUP_TYPE = 8'h05;
    localparam logic [7:0] PARAM_GROUP_CAPS = 8'h08;
    localparam logic [7:0] PARAM_POWER_STATES = 8'h0F;
    localparam logic [7:0] PARAM_PIN_CAPS = 8'h11;
    // Parameter fields
    localparam logic [3:0] MAJOR_COMPLIANCE_REVISION = 4'h1;
    localparam logic [3:0] MINOR_COMPLIANCE_REVISION = 4'h0;
    localparam logic [7:0] ROOT_FIRST_CHILD = 8'h01;
    localparam logic [7:0] ROOT_CHILD_COUNT = 8'h01;
    localparam logic [7:0] GROUP_FIRST_WIDGET = 8'h10;
    localparam logic [7:0] GROUP_WIDGET_COUNT = 8'h18;
    localparam logic [7:0] GROUP_TYPE_AUDIO = 8'h01;
    localparam logic [3:0] GROUP_INPUT_DELAY = 4'h3;
    localparam logic [3:0] GROUP_OUTPUT_DELAY = 4'h6;
    localparam logic [3:0] POWER_STATES_ALL = 4'hF;
    localparam logic [7:0] PINS_WITH_DIGITAL_OUT = 8'h01;
    localparam logic [7:0] PINS_ALL_GENERAL = 8'h02;
    localparam int SECOND_OUT_SEL_BIT = 4;
    // Power states
    localparam logic [3:0] POWER_D0 = 4'h0;
    localparam logic [3:0] POWER_D1 = 4'h1;
    localparam logic [3:0] POWER_D2 = 4'h2;
    localparam logic [3:0] POWER_D3 = 4'h3;
    // Event-report control fields, board identifier reset byte
    localparam int EVENT_ENABLE_BIT = 7;
    localparam logic [7:0] EVENT_CTRL_WRITE_MASK = 8'hBF;
    localparam logic [7:0] BOARD_LOW_BYTES_RESET = 8'h00;
endpackage
